// File: src/sfs_pkg.sv
// Constants, register map and state codes for the snapshot and flash sequencer.
// Assumes one 40 MHz core clock that is also the pixel clock of the timing core.
// Functional notes
// - Strobe register bit 14 marks fully flashed frames
// - Strobe: single shot, frame delay, xenon length
// - Reset: rolling shutter mode, shutter output low
// - Trigger on bit 0 rise or pin rise
// - Frame valid drops 6 clocks after line
// - Hold rows in reset, release all together
// - Readout starts at readout start count
// - Exactly one frame read, then rolling mode
// - First rolling frame after blanking plus exposure
// - Double buffers load at frame or readout
// - Shutter asserts at count, drops two rows after frame end
// - Flash bit pulses strobe during integration
// - Bulb mode: trigger level ends integration
// - Bulb: extend by readout minus shutter count
// - Rearm only after trigger released, shutter low
// - Streaming continues until sequence completes
package sfs_pkg;

	localparam logic [7:0] ADDR_STROBE   = 8'h00;
	localparam logic [7:0] ADDR_STRB_LEN = 8'h04;
	localparam logic [7:0] ADDR_RESTART  = 8'h08;
	localparam logic [7:0] ADDR_TRIG     = 8'h0c;
	localparam logic [7:0] ADDR_RST_END  = 8'h10;
	localparam logic [7:0] ADDR_SHUT_AT  = 8'h14;
	localparam logic [7:0] ADDR_READ_AT  = 8'h18;
	localparam logic [7:0] ADDR_STREAM   = 8'h1c;
	localparam logic [7:0] ADDR_ROW_LEN  = 8'h20;
	localparam logic [7:0] ADDR_ROW_EXP  = 8'h24;
	localparam logic [7:0] ADDR_VBLANK   = 8'h28;
	localparam logic [7:0] ADDR_STATUS   = 8'h2c;

	localparam int STRB_EN_BIT    = 0;
	localparam int STRB_ONCE_BIT  = 1;
	localparam int STRB_XENON_BIT = 2;
	localparam int STRB_DLY_LSB   = 4;
	localparam int STRB_GOOD_BIT  = 14;
	localparam int RESTART_BIT    = 1;
	localparam int TRIG_GO_BIT    = 0;
	localparam int TRIG_BULB_BIT  = 1;
	localparam int TRIG_FLASH_BIT = 2;
	localparam int STREAM_BIT     = 0;

	localparam logic [15:0] RST_END_RST  = 16'h00a0;
	localparam logic [15:0] SHUT_AT_RST  = 16'h0100;
	localparam logic [15:0] READ_AT_RST  = 16'h0200;
	localparam logic [15:0] ROW_LEN_RST  = 16'h0100;
	localparam logic [15:0] ROW_EXP_RST  = 16'h0010;
	localparam logic [15:0] VBLANK_RST   = 16'h0010;
	localparam logic [15:0] STRB_LEN_RST = 16'h0010;

	// Pixel clock and core clock are the same, so periods equal cycles
	localparam int FV_TRUNC_PCLK = 6;
	localparam int FV_TRUNC_CYC  = FV_TRUNC_PCLK;
	localparam int SHUT_NEG_ROWS = 2;
	localparam int FLASH_DLY_CYC = 4;

	typedef enum logic [3:0] {
		ST_ERS,
		ST_WAIT_LV,
		ST_TRUNC,
		ST_ROW_RST,
		ST_INTEG,
		ST_READ_WAIT,
		ST_READOUT,
		ST_SHUT_HOLD,
		ST_RESUME
	} sfs_state_t;

endpackage

// File: src/sfs_sequencer.sv
// Snapshot, mechanical shutter and flash strobe sequencer with APB registers.
// Assumes line and frame valid come from the timing core on core_clk.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
module sfs_sequencer (
	input  wire logic        core_clk,            // 40 MHz pixel clock
	input  wire logic        resetn,              // Async reset, active low
	input  wire logic        psel,                // APB select
	input  wire logic        penable,             // APB enable
	input  wire logic        pwrite,              // APB direction
	input  wire logic [7:0]  paddr,               // APB byte address
	input  wire logic [31:0] pwdata,              // APB write data
	output logic      [31:0] prdata,              // APB read data
	output logic             pready,              // APB ready
	output logic             pslverr,             // APB error, unmapped
	input  wire logic        line_valid_in,       // Line valid from timing core
	input  wire logic        frame_valid_in,      // Frame valid from timing core
	input  wire logic        general_input_pin,   // Asynchronous trigger pin
	input  wire logic        gpi_trig_en,         // Pin used as trigger
	output logic             line_valid,          // Gated line valid
	output logic             frame_valid,         // Gated frame valid
	output logic             pixel_clock_en,      // Pixel clock output enable
	output logic             flash_out,           // Flash strobe
	output logic             shutter_out,         // Mechanical shutter
	output logic             rows_in_reset,       // All rows held in reset
	output logic             rows_integrating,    // Global integration phase
	output logic             readout_start,       // Start one frame readout
	output logic             dbuf_update,         // Load double buffers
	output logic             restart_req,         // Forced restart pulse
	output logic             stream_active,       // Streaming state
	output logic             rolling_shutter_mode // Rolling shutter active
);
	typedef struct packed {
		sfs_pkg::sfs_state_t st;
		logic        strb_en;
		logic        strb_once;
		logic        strb_xenon;
		logic [2:0]  strb_dly;
		logic [15:0] strb_len;
		logic        trig_go;
		logic        trig_bulb;
		logic        trig_flash;
		logic        stream;
		logic [15:0] rst_end;
		logic [15:0] shut_at;
		logic [15:0] read_at;
		logic [15:0] row_len;
		logic [15:0] row_exp;
		logic [15:0] vblank;
		logic        s_bulb;
		logic        s_flash;
		logic        armed;
		logic        lv_d;
		logic        fv_d;
		logic [31:0] cnt;
		logic [31:0] aux;
		logic [2:0]  fr_dly;
		logic        fired;
		logic        led_on;
		logic [15:0] x_cnt;
		logic        lit;
		logic        good;
		logic        lv_q;
		logic        fv_q;
		logic        flash_q;
		logic        shut_q;
		logic        rst_q;
		logic        int_q;
		logic        rd_go_q;
		logic        dbuf_q;
		logic        restart_q;
		logic        strm_q;
		logic [31:0] prdata;
	} sfs_regs_t;

	sfs_regs_t   s;
	sfs_regs_t   n;
	logic        gpi_s;
	logic        trig_lvl;
	logic        fv_rise;
	logic        lv_fall;
	logic        hold;
	logic        snap_flash;
	logic        wr_acc;
	logic [31:0] rdata;
	logic [31:0] resume_cyc;

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= sfs_pkg::ADDR_STATUS);
	endfunction

	// States whose line and frame valid reach the outputs
	function automatic logic passes(input sfs_pkg::sfs_state_t st);
		return (st == sfs_pkg::ST_ERS) || (st == sfs_pkg::ST_WAIT_LV)
		    || (st == sfs_pkg::ST_TRUNC) || (st == sfs_pkg::ST_READ_WAIT)
		    || (st == sfs_pkg::ST_READOUT);
	endfunction

	sfs_sync #(.W(1)) u_gpi_sync (
		.clk   (core_clk),
		.rst_n (resetn),
		.d     (general_input_pin),
		.q     (gpi_s)
	);

	assign trig_lvl = s.trig_go | (gpi_trig_en & gpi_s);
	assign fv_rise  = frame_valid_in & ~s.fv_d;
	assign lv_fall  = ~line_valid_in & s.lv_d;
	assign wr_acc   = psel & penable & pwrite & mapped(paddr);
	assign hold     = s.s_bulb && (s.cnt == 32'(s.shut_at)) && trig_lvl;
	// Product is at most 33 bits; top bit dropped as unrealistic
	assign resume_cyc = 32'((17'(s.vblank) + 17'(s.row_exp)) * s.row_len);
	assign snap_flash = (s.st == sfs_pkg::ST_INTEG) && s.s_flash
	                 && (s.aux >= 32'(sfs_pkg::FLASH_DLY_CYC))
	                 && (s.aux < 32'(sfs_pkg::FLASH_DLY_CYC) + 32'(s.strb_len));

	always_comb
	begin
		rdata = 32'h0;
		case (paddr)
			sfs_pkg::ADDR_STROBE:
			begin
				rdata[sfs_pkg::STRB_EN_BIT]           = s.strb_en;
				rdata[sfs_pkg::STRB_ONCE_BIT]         = s.strb_once;
				rdata[sfs_pkg::STRB_XENON_BIT]        = s.strb_xenon;
				rdata[sfs_pkg::STRB_DLY_LSB +: 3]     = s.strb_dly;
				rdata[sfs_pkg::STRB_GOOD_BIT]         = s.good;
			end
			sfs_pkg::ADDR_STRB_LEN: rdata[15:0] = s.strb_len;
			sfs_pkg::ADDR_TRIG:
			begin
				rdata[sfs_pkg::TRIG_GO_BIT]    = s.trig_go;
				rdata[sfs_pkg::TRIG_BULB_BIT]  = s.trig_bulb;
				rdata[sfs_pkg::TRIG_FLASH_BIT] = s.trig_flash;
			end
			sfs_pkg::ADDR_RST_END: rdata[15:0] = s.rst_end;
			sfs_pkg::ADDR_SHUT_AT: rdata[15:0] = s.shut_at;
			sfs_pkg::ADDR_READ_AT: rdata[15:0] = s.read_at;
			sfs_pkg::ADDR_STREAM:  rdata[sfs_pkg::STREAM_BIT] = s.stream;
			sfs_pkg::ADDR_ROW_LEN: rdata[15:0] = s.row_len;
			sfs_pkg::ADDR_ROW_EXP: rdata[15:0] = s.row_exp;
			sfs_pkg::ADDR_VBLANK:  rdata[15:0] = s.vblank;
			sfs_pkg::ADDR_STATUS:  rdata[6:0]  = {s.strm_q, s.flash_q, s.shut_q, s.st};
			default:               rdata = 32'h0;
		endcase
	end

	always_comb
	begin
		n           = s;
		n.rd_go_q   = 1'b0;
		n.dbuf_q    = 1'b0;
		n.restart_q = 1'b0;
		n.lv_d      = line_valid_in;
		n.fv_d      = frame_valid_in;
		// Read data sampled in setup so it stands from a flop in access
		if (psel && !penable)
			n.prdata = rdata;
		if (wr_acc)
		begin
			case (paddr)
				sfs_pkg::ADDR_STROBE:
				begin
					n.strb_en    = pwdata[sfs_pkg::STRB_EN_BIT];
					n.strb_once  = pwdata[sfs_pkg::STRB_ONCE_BIT];
					n.strb_xenon = pwdata[sfs_pkg::STRB_XENON_BIT];
					n.strb_dly   = pwdata[sfs_pkg::STRB_DLY_LSB +: 3];
				end
				sfs_pkg::ADDR_STRB_LEN: n.strb_len = pwdata[15:0];
				// restart pulse masks the partly lit frame
				sfs_pkg::ADDR_RESTART:  n.restart_q = pwdata[sfs_pkg::RESTART_BIT];
				sfs_pkg::ADDR_TRIG:
				begin
					n.trig_go    = pwdata[sfs_pkg::TRIG_GO_BIT];
					n.trig_bulb  = pwdata[sfs_pkg::TRIG_BULB_BIT];
					n.trig_flash = pwdata[sfs_pkg::TRIG_FLASH_BIT];
				end
				sfs_pkg::ADDR_RST_END: n.rst_end = pwdata[15:0];
				sfs_pkg::ADDR_SHUT_AT: n.shut_at = pwdata[15:0];
				sfs_pkg::ADDR_READ_AT: n.read_at = pwdata[15:0];
				sfs_pkg::ADDR_STREAM:  n.stream  = pwdata[sfs_pkg::STREAM_BIT];
				sfs_pkg::ADDR_ROW_LEN: n.row_len = pwdata[15:0];
				sfs_pkg::ADDR_ROW_EXP: n.row_exp = pwdata[15:0];
				sfs_pkg::ADDR_VBLANK:  n.vblank  = pwdata[15:0];
				default:               n.vblank  = s.vblank;
			endcase
		end

		// rearm only with trigger low and shutter released
		if (!trig_lvl && (s.st == sfs_pkg::ST_ERS || s.st == sfs_pkg::ST_RESUME))
			n.armed = 1'b1;

		case (s.st)
			sfs_pkg::ST_ERS, sfs_pkg::ST_RESUME:
			begin
				// edge start from register bit or pin
				if (s.armed && trig_lvl)
				begin
					n.s_bulb  = s.trig_bulb;
					n.s_flash = s.trig_flash;
					n.armed   = 1'b0;
					n.led_on  = 1'b0;
					n.x_cnt   = 16'h0;
					n.cnt     = 32'h0;
					n.st      = s.fv_d ? sfs_pkg::ST_WAIT_LV : sfs_pkg::ST_ROW_RST;
				end
				else if (s.st == sfs_pkg::ST_RESUME)
				begin
					if (s.aux == 32'h0)
						n.st = sfs_pkg::ST_ERS;
					else
						n.aux = s.aux - 32'h1;
				end
			end
			sfs_pkg::ST_WAIT_LV:
			begin
				if (lv_fall)
				begin
					n.st  = sfs_pkg::ST_TRUNC;
					n.aux = 32'(sfs_pkg::FV_TRUNC_CYC - 1);
				end
				else if (!frame_valid_in)
					n.st = sfs_pkg::ST_ROW_RST;
			end
			sfs_pkg::ST_TRUNC:
			begin
				// frame valid cut after the fixed delay
				if (s.aux == 32'h0)
					n.st = sfs_pkg::ST_ROW_RST;
				else
					n.aux = s.aux - 32'h1;
			end
			sfs_pkg::ST_ROW_RST:
			begin
				n.cnt = s.cnt + 32'h1;
				if (s.cnt == 32'(s.rst_end))
				begin
					n.st  = sfs_pkg::ST_INTEG;
					n.aux = 32'h0;
				end
			end
			sfs_pkg::ST_INTEG:
			begin
				n.aux = s.aux + 32'h1;
				// bulb release adds readout minus shutter count
				if (!hold)
					n.cnt = s.cnt + 32'h1;
				if (s.cnt == 32'(s.read_at) && !hold)
				begin
					n.st      = sfs_pkg::ST_READ_WAIT;
					n.rd_go_q = 1'b1;
					n.dbuf_q  = 1'b1;
				end
			end
			sfs_pkg::ST_READ_WAIT:
			begin
				if (frame_valid_in)
					n.st = sfs_pkg::ST_READOUT;
			end
			sfs_pkg::ST_READOUT:
			begin
				if (!frame_valid_in)
				begin
					n.st  = sfs_pkg::ST_SHUT_HOLD;
					n.aux = 32'(s.row_len) * 32'(sfs_pkg::SHUT_NEG_ROWS);
				end
			end
			sfs_pkg::ST_SHUT_HOLD:
			begin
				// shutter drops two rows after frame end
				if (s.aux == 32'h0)
				begin
					n.shut_q = 1'b0;
					n.st     = sfs_pkg::ST_RESUME;
					n.aux    = resume_cyc;
				end
				else
					n.aux = s.aux - 32'h1;
			end
			default: n.st = sfs_pkg::ST_ERS;
		endcase

		// shutter asserts when its count is reached
		if ((s.st == sfs_pkg::ST_ROW_RST || s.st == sfs_pkg::ST_INTEG)
		    && s.cnt == 32'(s.shut_at))
			n.shut_q = 1'b1;

		if (s.x_cnt != 16'h0)
			n.x_cnt = s.x_cnt - 16'h1;
		if (!s.strb_en)
		begin
			n.led_on = 1'b0;
			n.fr_dly = s.strb_dly;
			n.fired  = 1'b0;
		end
		else if (fv_rise && s.st == sfs_pkg::ST_ERS)
		begin
			if (s.fr_dly != 3'h0)
				n.fr_dly = s.fr_dly - 3'h1;
			else if (!(s.strb_once && s.fired))
			begin
				n.fired = 1'b1;
				if (s.strb_xenon)
				begin
					n.x_cnt  = s.strb_len;
					n.led_on = 1'b0;
				end
				else
					n.led_on = 1'b1;
			end
			else
				n.led_on = 1'b0;
		end
		n.flash_q = n.led_on | (n.x_cnt != 16'h0) | snap_flash;

		// mark frames lit from start to end
		if (fv_rise)
		begin
			n.good = s.lit;
			n.lit  = n.led_on | (n.x_cnt != 16'h0);
		end
		else if (!s.flash_q && !s.strb_xenon)
			n.lit = 1'b0;
		if (n.restart_q)
			n.lit = 1'b0;

		// rolling mode loads at every frame start
		if (fv_rise && s.st == sfs_pkg::ST_ERS)
			n.dbuf_q = 1'b1;

		n.rst_q  = (n.st == sfs_pkg::ST_ROW_RST);
		n.int_q  = (n.st == sfs_pkg::ST_INTEG);
		// gate on next state
		// Registered gate would cut frame valid one clock late
		n.lv_q   = line_valid_in & passes(n.st);
		n.fv_q   = frame_valid_in & passes(n.st);
		// a running sequence keeps the stream alive
		n.strm_q = s.stream | (s.st != sfs_pkg::ST_ERS);
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		// rolling mode and shutter low out of reset
		if (!resetn)
		begin
			s          <= '0;
			s.rst_end  <= sfs_pkg::RST_END_RST;
			s.shut_at  <= sfs_pkg::SHUT_AT_RST;
			s.read_at  <= sfs_pkg::READ_AT_RST;
			s.row_len  <= sfs_pkg::ROW_LEN_RST;
			s.row_exp  <= sfs_pkg::ROW_EXP_RST;
			s.vblank   <= sfs_pkg::VBLANK_RST;
			s.strb_len <= sfs_pkg::STRB_LEN_RST;
		end
		else
			s <= n;
	end

	assign prdata               = s.prdata;
	assign pready               = 1'b1;
	assign pslverr              = psel & penable & ~mapped(paddr);
	assign line_valid           = s.lv_q;
	assign frame_valid          = s.fv_q;
	assign pixel_clock_en       = s.strm_q;
	assign flash_out            = s.flash_q;
	assign shutter_out          = s.shut_q;
	assign rows_in_reset        = s.rst_q;
	assign rows_integrating     = s.int_q;
	assign readout_start        = s.rd_go_q;
	assign dbuf_update          = s.dbuf_q;
	assign restart_req          = s.restart_q;
	assign stream_active        = s.strm_q;
	assign rolling_shutter_mode = (s.st == sfs_pkg::ST_ERS) || (s.st == sfs_pkg::ST_WAIT_LV)
	                           || (s.st == sfs_pkg::ST_TRUNC);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_good_at_start: assert property ($changed(s.good) |-> $past(fv_rise))
		else $error("good-frame flag moved outside frame start");
	a_strobe_off: assert property (!s.strb_en |=> !s.led_on)
		else $error("LED strobe on while disabled");
	a_ers_shut_low: assert property (s.st == sfs_pkg::ST_ERS |-> !s.shut_q)
		else $error("shutter high in rolling mode");
	a_trig_start: assert property (
		(s.st == sfs_pkg::ST_ERS && s.armed && trig_lvl) |=> s.st != sfs_pkg::ST_ERS)
		else $error("trigger edge not taken");
	a_trunc_six: assert property (
		$rose(s.st == sfs_pkg::ST_TRUNC) |->
		(s.st == sfs_pkg::ST_TRUNC)[*6] ##1 (s.st == sfs_pkg::ST_ROW_RST))
		else $error("truncation delay not six cycles");
	a_rows_release: assert property ($fell(s.rst_q) |-> s.int_q)
		else $error("rows not released together");
	a_read_start: assert property (
		(s.st == sfs_pkg::ST_INTEG && s.cnt == 32'(s.read_at) && !hold)
		|=> s.rd_go_q && !s.int_q)
		else $error("readout not started at count");
	a_one_frame: assert property (
		(s.st == sfs_pkg::ST_READOUT && !frame_valid_in) |=> s.st == sfs_pkg::ST_SHUT_HOLD)
		else $error("readout did not end after one frame");
	a_dbuf_read: assert property (s.rd_go_q |-> s.dbuf_q)
		else $error("double buffers not loaded before readout");
	a_shut_assert: assert property (
		((s.st == sfs_pkg::ST_ROW_RST || s.st == sfs_pkg::ST_INTEG)
		 && s.cnt == 32'(s.shut_at)) |=> s.shut_q)
		else $error("shutter missed its count");
	a_snap_flash: assert property (
		(s.st == sfs_pkg::ST_INTEG && s.s_flash && s.aux == 32'(sfs_pkg::FLASH_DLY_CYC)
		 && s.strb_len != 16'h0) |=> s.flash_q)
		else $error("snapshot flash did not fire");
	a_bulb_hold: assert property (hold |=> $stable(s.cnt))
		else $error("bulb hold let the count run");
	a_rearm_wait: assert property (
		(s.st == sfs_pkg::ST_ERS && !s.armed) |=> s.st == sfs_pkg::ST_ERS)
		else $error("sequence retriggered without release");
	a_stream_hold: assert property (
		(s.st != sfs_pkg::ST_ERS && $past(s.st) != sfs_pkg::ST_ERS) |-> s.strm_q)
		else $error("streaming stopped mid sequence");
endmodule // sfs_sequencer

// File: src/sfs_sync.sv
// Two-flop synchroniser for asynchronous pins.
// Assumes the destination clock is the core clock.
`timescale 1ns/100ps
module sfs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // Destination clock
	input  wire logic         rst_n,  // Async reset, active low
	input  wire logic [W-1:0] d,      // Asynchronous input
	output logic      [W-1:0] q       // Synchronised output
);
	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_r[i] <= 1'b0;
					q[i]      <= 1'b0;
				end
				else
				begin
					meta_r[i] <= d[i];
					q[i]      <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule // sfs_sync

// File: verif/sfs_timing_model.sv
// Timing core stand-in: rolling frames, one frame per readout request.
// Assumes requests are one-cycle pulses on the core clock.
`timescale 1ns/100ps
module sfs_timing_model #(
	parameter int ROWS = 3, // Lines per frame
	parameter int LINE = 8  // Clocks per line
) (
	input  wire logic core_clk,             // Core clock
	input  wire logic resetn,               // Async reset, active low
	input  wire logic readout_start,        // One frame request
	input  wire logic rolling_shutter_mode, // Free running frames
	output logic      line_valid_in,        // Line valid out
	output logic      frame_valid_in        // Frame valid out
);
	int reqs = 0;
	int done = 0;
	always @(posedge core_clk)
		if (readout_start === 1'b1)
			reqs <= reqs + 1;
	task automatic frame();
		logic one;
		one = (reqs != done);
		if (one)
			done++;
		frame_valid_in <= 1'b1;
		repeat (2) @(posedge core_clk);
		for (int r = 0; r < ROWS; r++)
		begin
			line_valid_in <= 1'b1;
			repeat (LINE) @(posedge core_clk);
			line_valid_in <= 1'b0;
			// Gap outlasts truncation, so a cut frame ends here
			repeat (8) @(posedge core_clk);
			if (!one && rolling_shutter_mode !== 1'b1)
				break;
		end
		frame_valid_in <= 1'b0;
		repeat (10) @(posedge core_clk);
	endtask
	initial
	begin
		line_valid_in = 1'b0;
		frame_valid_in = 1'b0;
		forever
		begin
			@(posedge core_clk);
			if (resetn === 1'b1 && (reqs != done || rolling_shutter_mode === 1'b1))
				frame();
		end
	end
endmodule // sfs_timing_model

// File: verif/snapshot_flash_shutter_sequencer_bench.sv
// Bench for the sequencer: APB master, timing model, run-length monitors.
// Assumes the timing model returns three-line frames.
`timescale 1ns/100ps
module snapshot_flash_shutter_sequencer_bench;
	logic        core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic        pready, pslverr, serr, lv_in, fv_in, pin = 0, pin_en = 0, sro;
	logic        lv, fv, pce, flash, shut, rir, integ, ro, dbu, rreq, sact, rsm;
	int num_errors = 0, checked = 0, cyc = 0;
	integer seed = 32'h3efcc67b;
	int t_rir, t_shr, t_shf, t_fvi, t_lvf, t_fvf, t_ro, t_rsm, fvr, lvr, rrq, t_rel;
	int run[4], len[4];
	logic [3:0] m;

	always #12.5 core_clk = ~core_clk;

	sfs_sequencer dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_valid_in(lv_in), .frame_valid_in(fv_in),
		.general_input_pin(pin), .gpi_trig_en(pin_en), .line_valid(lv), .frame_valid(fv),
		.pixel_clock_en(pce), .flash_out(flash), .shutter_out(shut), .rows_in_reset(rir),
		.rows_integrating(integ), .readout_start(ro), .dbuf_update(dbu), .restart_req(rreq),
		.stream_active(sact), .rolling_shutter_mode(rsm));
	sfs_timing_model tm (.core_clk(core_clk), .resetn(resetn), .readout_start(ro),
		.rolling_shutter_mode(rsm), .line_valid_in(lv_in), .frame_valid_in(fv_in));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g)
		begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	always @(posedge core_clk)
	begin
		m = {flash, shut, integ, rir};
		if ($rose(rir)) t_rir = cyc;
		if ($rose(shut)) t_shr = cyc;
		if ($fell(shut)) t_shf = cyc;
		if ($fell(fv_in)) t_fvi = cyc;
		if ($fell(lv)) t_lvf = cyc;
		if ($fell(fv)) t_fvf = cyc;
		if ($rose(rsm)) t_rsm = cyc;
		if ($rose(fv)) fvr++;
		if ($rose(lv)) lvr++;
		if (rreq === 1'b1) rrq++;
		if (ro === 1'b1)
		begin
			t_ro = cyc;
			fvr = 0;
			lvr = 0;
			sro = sact;
			chk("dbuf_update", 1, dbu);
			// Host program keeps the shutter closed before integration ends
			chk("shut_closed", 1, shut);
		end
		for (int i = 0; i < 4; i++)
			if (m[i] === 1'b1) run[i]++;
			else if (run[i] > 0)
			begin
				len[i] = run[i];
				run[i] = 0;
			end
		cyc++;
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a stuck access
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_mode(input int t0);
		do @(posedge core_clk); while (rsm !== 1'b1 || t_ro <= t0);
		#1;
	endtask

	task snap(input int rst, input int sh, input int rdat, input logic fl, input logic bulb);
		int t0;
		len = '{0, 0, 0, 0};
		apb(1, sfs_pkg::ADDR_RST_END, rst);
		apb(1, sfs_pkg::ADDR_SHUT_AT, sh);
		// Readout count kept above shutter count
		apb(1, sfs_pkg::ADDR_READ_AT, rdat);
		apb(1, sfs_pkg::ADDR_TRIG, {29'h0, fl, bulb, 1'b0});
		pin_en <= bulb;
		t0 = cyc;
		@(posedge lv_in);
		if (bulb) pin <= 1'b1;
		else apb(1, sfs_pkg::ADDR_TRIG, {29'h0, fl, 1'b0, 1'b1});
		for (int n = 0; n < 60 && fv !== 1'b0; n++) @(posedge core_clk);
		#1 chk("truncate", 6, t_fvf - t_lvf);
		apb(1, sfs_pkg::ADDR_STREAM, 0);
		if (bulb)
		begin
			// Pin held well past the shutter count
			repeat (60) @(posedge core_clk);
			t_rel = cyc;
			pin <= 1'b0;
		end
		wait_mode(t0);
		chk("reset_len", rst + 1, len[0]);
		if (bulb)
			chk("bulb_tail", 1, (t_ro - t_rel) inside {[rdat-sh:rdat-sh+5]});
		else
			chk("integ_len", rdat - rst, len[1]);
		// Shutter flop follows the count match by one clock
		chk("shut_on", sh + 1, t_shr - t_rir);
		// Shutter reopens inside the window of 8 to 10 clocks after frame end
		chk("shut_off", 1, (t_shf - t_fvi) inside {[8:10]});
		chk("frames", 1, fvr);
		chk("lines", 3, lvr);
		chk("resume", 1, (t_rsm - t_shf) inside {[6:11]});
		chk("stream_hold", 1, sro);
		if (fl) chk("flash_len", 3, len[3]);
		repeat (20) @(posedge core_clk);
		#1 chk("no_retrigger", 0, cyc - t0 > 0 && t_rir > t_shf);
		chk("stream_off", 0, sact);
		apb(1, sfs_pkg::ADDR_TRIG, 0);
		apb(1, sfs_pkg::ADDR_STREAM, 1);
		$display("test snapshot done rst=%0d bulb=%0d", rst, bulb);
	endtask

	task print_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge core_clk);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		int r;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		#1 chk("shut_reset", 0, shut);
		chk("rolling_reset", 1, rsm);
		// Reset end count defaults to the advised value
		apb(0, sfs_pkg::ADDR_RST_END, 0);
		chk("rst_end", 32'ha0, rd);
		apb(0, 8'h30, 0);
		chk("unmapped", 1, serr);
		apb(1, sfs_pkg::ADDR_ROW_LEN, 4);
		apb(1, sfs_pkg::ADDR_ROW_EXP, 1);
		apb(1, sfs_pkg::ADDR_VBLANK, 1);
		apb(1, sfs_pkg::ADDR_STRB_LEN, 3);
		apb(1, sfs_pkg::ADDR_STREAM, 1);
		for (int k = 0; k < 2; k++)
		begin
			r = $unsigned($random(seed)) % 4;
			snap(2 + r, 4 + r, 16 + r, k[0], 1'b0);
		end
		snap(4, 6, 7, 1'b1, 1'b1);
		// Strobe on, then a forced restart
		apb(1, sfs_pkg::ADDR_STROBE, 1);
		apb(1, sfs_pkg::ADDR_RESTART, 2);
		// Pulse is seen one clock after the write edge
		@(posedge core_clk);
		#1 chk("restart", 1, rrq);
		repeat (3) @(posedge fv_in);
		apb(0, sfs_pkg::ADDR_STROBE, 0);
		chk("good_bit", 1, rd[sfs_pkg::STRB_GOOD_BIT]);
		chk("led_on", 1, flash);
		// LED level off first, so the xenon pulse stands alone
		apb(1, sfs_pkg::ADDR_STROBE, 0);
		apb(1, sfs_pkg::ADDR_STROBE, 5);
		len[3] = 0;
		repeat (2) @(posedge fv_in);
		repeat (20) @(posedge core_clk);
		#1 chk("xenon_len", 3, len[3]);
		apb(1, sfs_pkg::ADDR_STROBE, 0);
		repeat (2) @(posedge fv_in);
		apb(0, sfs_pkg::ADDR_STROBE, 0);
		chk("good_off", 0, rd[sfs_pkg::STRB_GOOD_BIT]);
		$display("test strobe done");
		print_verdict();
	end
endmodule // snapshot_flash_shutter_sequencer_bench
